// ---- pfbcp_pkg.sv ----
// shared constants and carrier types for the parallel flash host controller
package pfbcp_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;

  // bus timing at 100 MHz (10 ns)
  localparam int CLK_NS       = 10;
  localparam int SETUP_NS     = 20;
  localparam int STROBE_NS    = 50;
  localparam int HOLD_NS      = 20;
  localparam int IDLE_STBY_NS = 150;
  localparam int RESET_ABORT_US = 10;
  localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC     = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int STBY_CYC     = (IDLE_STBY_NS + CLK_NS - 1) / CLK_NS;
  localparam int ABORT_CYC    = (RESET_ABORT_US * 1000 + CLK_NS - 1) / CLK_NS;
  // wide enough for the full abort wait, which is the longest count
  localparam int CNT_W        = 14;

  // command sequence values, only low 11 address bits matter
  localparam logic [10:0] UNLOCK_ADDR1 = 11'h555;
  localparam logic [10:0] UNLOCK_ADDR2 = 11'h2aa;
  localparam logic [7:0]  UNLOCK_DATA1 = 8'haa;
  localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0]  CMD_RESET    = 8'hf0;
  localparam logic [7:0]  CMD_IDENT    = 8'h90;
  localparam logic [7:0]  CMD_PROGRAM  = 8'ha0;

  // identification read addresses
  localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 19'h00000;
  localparam logic [ADDR_W-1:0] ID_PART_ADDR  = 19'h00001;
  localparam logic [ADDR_W-1:0] ID_PROT_ADDR  = 19'h00002;

  typedef enum logic [2:0]
  {
    OP_READ     = 3'h0,
    OP_RESET1   = 3'h1,
    OP_RESET3   = 3'h2,
    OP_IDENT    = 3'h3,
    OP_PROGRAM  = 3'h4,
    OP_ID_READ  = 3'h5
  } pfbcp_op_t;

  typedef struct packed
  {
    pfbcp_op_t         op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pfbcp_req_t;

  typedef struct packed
  {
    logic              chipEnN;
    logic              outEnN;
    logic              writeEnN;
    logic              idLevel;
    logic [ADDR_W-1:0] addressLines;
  } pfbcp_pins_t;
endpackage

// ---- pfbcp_host.sv ----
// host-side controller that drives the parallel flash through its pins
`timescale 1ns/1ps
// What this block does
// - read: address, chip and output enable low, write enable high; sample byte
// - output enable stays high through every write
// - id codes read with elevated level on address bit 9, bit 0 selects
// - program takes four writes; fourth carries target address and data
// - success returns read mode; error keeps status until reset command
module pfbcp_host
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // request side
  input  wire logic                        reqValid,
  input  wire pfbcp_pkg::pfbcp_req_t       req,
  output logic                             reqReady,
  output logic                             rspValid,
  output logic [pfbcp_pkg::DATA_W-1:0]     rspData,
  // flash pins
  output pfbcp_pkg::pfbcp_pins_t           pins,
  output logic [pfbcp_pkg::DATA_W-1:0]     dataLinesOut,
  output logic                             dataLinesOeN,
  input  wire logic [pfbcp_pkg::DATA_W-1:0] dataLinesIn
);
  typedef enum logic [4:0]
  {
    ST_IDLE   = 5'b00001,
    ST_SETUP  = 5'b00010,
    ST_STROBE = 5'b00100,
    ST_HOLD   = 5'b01000,
    ST_WAIT   = 5'b10000
  } pfbcp_state_t;

  pfbcp_state_t                    state_q;
  pfbcp_pkg::pfbcp_req_t           cur_q;
  logic [2:0]                      step_q;
  logic [2:0]                      lastStep;
  logic [pfbcp_pkg::CNT_W-1:0]     cnt_q;
  logic [pfbcp_pkg::DATA_W-1:0]    sync1_q;
  logic [pfbcp_pkg::DATA_W-1:0]    sync2_q;
  logic [pfbcp_pkg::DATA_W-1:0]    rdByte_q;
  logic                            isRead;
  logic [pfbcp_pkg::ADDR_W-1:0]    stepAddr;
  logic [pfbcp_pkg::DATA_W-1:0]    stepData;

  function automatic logic [pfbcp_pkg::CNT_W-1:0] cyc(input int n);
    cyc = pfbcp_pkg::CNT_W'(n - 1);
  endfunction

  assign isRead = (cur_q.op == pfbcp_pkg::OP_READ) || (cur_q.op == pfbcp_pkg::OP_ID_READ);

  // number of bus cycles per operation, last index
  always_comb
  begin
    unique case (cur_q.op)
      pfbcp_pkg::OP_RESET3:  lastStep = 3'h2;
      pfbcp_pkg::OP_IDENT:   lastStep = 3'h2;
      pfbcp_pkg::OP_PROGRAM: lastStep = 3'h3;
      default:               lastStep = 3'h0;
    endcase
  end

  // unlock prefix, command byte, then program address/data
  always_comb
  begin
    stepAddr = {8'h00, pfbcp_pkg::UNLOCK_ADDR1};
    stepData = pfbcp_pkg::CMD_RESET;
    if (isRead || cur_q.op == pfbcp_pkg::OP_RESET1)
    begin
      stepAddr = cur_q.addr;
      stepData = pfbcp_pkg::CMD_RESET;
    end
    else if (step_q == 3'h0)
      stepData = pfbcp_pkg::UNLOCK_DATA1;
    else if (step_q == 3'h1)
    begin
      stepAddr = {8'h00, pfbcp_pkg::UNLOCK_ADDR2};
      stepData = pfbcp_pkg::UNLOCK_DATA2;
    end
    else if (step_q == 3'h2)
    begin
      if (cur_q.op == pfbcp_pkg::OP_IDENT)
        stepData = pfbcp_pkg::CMD_IDENT;
      else if (cur_q.op == pfbcp_pkg::OP_PROGRAM)
        stepData = pfbcp_pkg::CMD_PROGRAM;
      else
        stepData = pfbcp_pkg::CMD_RESET;  // clears a latched program error
    end
    else
    begin
      stepAddr = cur_q.addr;
      stepData = cur_q.data;
    end
  end

  // read data from the pins crosses in through two flops
  always_ff @(posedge clk)
  begin
    sync1_q <= dataLinesIn;
    sync2_q <= sync1_q;
  end

  // sequencer
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      cur_q   <= '0;
      step_q  <= 3'h0;
      cnt_q   <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (reqValid)
          begin
            cur_q   <= req;
            step_q  <= 3'h0;
            cnt_q   <= cyc(pfbcp_pkg::SETUP_CYC);
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          // address settles before the falling strobe edge
          if (cnt_q == '0)
          begin
            cnt_q   <= cyc(pfbcp_pkg::STROBE_CYC);
            state_q <= ST_STROBE;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        ST_STROBE:
        begin
          // reads allow extra cycles for the two-flop input path
          if (cnt_q == '0)
          begin
            cnt_q   <= isRead ? cyc(pfbcp_pkg::HOLD_CYC + 2) : cyc(pfbcp_pkg::HOLD_CYC);
            state_q <= ST_HOLD;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        ST_HOLD:
        begin
          // data stays put past the rising strobe edge
          if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
          else if (step_q != lastStep)
          begin
            step_q  <= step_q + 3'h1;  // whole sequence, broken only by reset
            cnt_q   <= cyc(pfbcp_pkg::SETUP_CYC);
            state_q <= ST_SETUP;
          end
          else if (cur_q.op == pfbcp_pkg::OP_RESET1 || cur_q.op == pfbcp_pkg::OP_RESET3)
          begin
            cnt_q   <= cyc(pfbcp_pkg::ABORT_CYC);
            state_q <= ST_WAIT;
          end
          else
            state_q <= ST_IDLE;
        end
        ST_WAIT:
        begin
          if (cnt_q == '0)
            state_q <= ST_IDLE;
          else
            cnt_q <= cnt_q - 1'b1;
        end
      endcase
    end
  end

  // pin drive, all registered
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pins.chipEnN      <= 1'b1;
      pins.outEnN       <= 1'b1;
      pins.writeEnN     <= 1'b1;
      pins.idLevel      <= 1'b0;
      pins.addressLines <= '0;
      dataLinesOut      <= '0;
      dataLinesOeN      <= 1'b1;
    end
    else
    begin
      pins.addressLines <= stepAddr;
      dataLinesOut      <= stepData;
      pins.idLevel      <= (state_q != ST_IDLE) && (state_q != ST_WAIT) &&
                           (cur_q.op == pfbcp_pkg::OP_ID_READ);
      pins.chipEnN      <= !((state_q == ST_SETUP) || (state_q == ST_STROBE));
      pins.writeEnN     <= !((state_q == ST_STROBE) && !isRead);
      pins.outEnN       <= !((state_q == ST_STROBE) && isRead);
      // drive data only on writes, when the device has released the lines
      dataLinesOeN      <= !(((state_q == ST_SETUP) || (state_q == ST_STROBE) ||
                              (state_q == ST_HOLD)) && !isRead);
    end
  end

  // handshake and read answer
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspData  <= '0;
      rdByte_q <= '0;
    end
    else
    begin
      reqReady <= (state_q == ST_IDLE) && !reqValid;
      rspValid <= 1'b0;
      // sync2 lags the pins by two edges; later it shows released lines
      if (state_q == ST_HOLD && isRead && cnt_q == cyc(2))
        rdByte_q <= sync2_q;
      if (state_q == ST_HOLD && cnt_q == '0 && step_q == lastStep)
      begin
        rspValid <= 1'b1;
        // status, id or array byte as the device's mode dictates
        rspData  <= isRead ? rdByte_q : '0;
      end
    end
  end
endmodule

// ---- pfbcp_flash_model.sv ----
// behavioural flash device facing the host controller
`timescale 1ns/1ps
module pfbcp_flash_model
#(
  parameter logic [7:0] MAKER    = 8'h3c, // arbitrary value
  parameter logic [7:0] PART     = 8'hc3, // arbitrary value
  parameter logic [7:0] ST_RUN   = 8'h4c,
  parameter logic [7:0] ST_ERR   = 8'h6c,
  parameter logic [2:0] PROT     = 3'h7,
  parameter int         PROG_NS  = 220,
  parameter int         ABORT_NS = 10000
)
(
  // strobes and address
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic        idLvl,
  input  wire logic [18:0] a,
  // data lines
  input  wire logic [7:0]  din,
  output wire logic [7:0]  dq
);
  logic [7:0]  mem [0:127];
  logic [18:0] la;
  logic [18:0] pa;
  logic [7:0]  pd;
  logic [7:0]  v;
  logic [1:0]  step = 0;
  logic        idMode = 0;
  logic        busy = 0;
  logic        err = 0;
  logic        abort = 0;
  logic        bad = 0;
  logic        wrOpen = 0;
  initial foreach (mem[i]) mem[i] = 8'hff;
  always @(negedge ceN or negedge weN)
  begin
    if (!ceN && !weN)
    begin
      la = a;
      wrOpen = 1;
    end
  end
  // deselected strobes never reach the decoder; a joint rise of both counts once
  always @(posedge ceN or posedge weN)
  begin
    if (wrOpen)
    begin
      wrOpen = 0;
      cmd(din);
    end
  end
  task automatic cmd(input logic [7:0] d);
    logic u1;
    u1 = la[10:0] == 11'h555;
    if (busy) ;
    else if (step == 2'd3)
    begin
      step = 0;
      bad = |(d & ~mem[{la[18:16], la[3:0]}]);
      pa = la;
      pd = d;
      if (la[18:16] != PROT) busy = 1;
    end
    else if (d == 8'hf0 && step != 2'd1)
    begin
      if (err) abort = 1;
      {step, idMode, err} = 0;
    end
    else if (step == 0 && u1 && d == 8'haa) step = 1;
    else if (step == 1 && la[10:0] == 11'h2aa && d == 8'h55) step = 2;
    else if (step == 2 && u1 && d == 8'h90) {step, idMode} = 3'b001;
    else if (step == 2 && u1 && d == 8'ha0) step = 3;
    else {step, idMode} = 0;
  endtask
  always @(posedge busy)
  begin
    #(PROG_NS);
    if (bad) err = 1;
    else mem[{pa[18:16], pa[3:0]}] = pd;
    busy = 0;
  end
  always @(posedge abort) #(ABORT_NS) abort = 0;
  always_comb
  begin
    if (busy) v = ST_RUN;
    else if (err) v = ST_ERR;
    else if ((idLvl || idMode) && a[1:0] == 2'b00) v = MAKER;
    else if ((idLvl || idMode) && a[1:0] == 2'b01) v = PART;
    else if (idMode && a[1:0] == 2'b10) v = {7'h0, a[18:16] == PROT};
    else v = mem[{a[18:16], a[3:0]}];
  end
  // released lines show the inverse so a stale byte cannot pass
  assign dq = (!ceN && !oeN && weN && !abort) ? v : ~v;
endmodule

// ---- pfbcp_host_assertions.sv ----
// concurrent checks on the flash host ports
`timescale 1ns/1ps
module pfbcp_host_assertions
(
  // clock and reset
  input wire logic                         clk,
  input wire logic                         reset,
  // request side
  input wire logic                         reqValid,
  input wire pfbcp_pkg::pfbcp_req_t        req,
  input wire logic                         reqReady,
  input wire logic                         rspValid,
  input wire logic [pfbcp_pkg::DATA_W-1:0] rspData,
  // flash pins
  input wire pfbcp_pkg::pfbcp_pins_t       pins,
  input wire logic [pfbcp_pkg::DATA_W-1:0] dataLinesOut,
  input wire logic                         dataLinesOeN,
  input wire logic [pfbcp_pkg::DATA_W-1:0] dataLinesIn
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  rd_strobes_a: assert property (!pins.outEnN |-> !pins.chipEnN && pins.writeEnN)
    else $error("read strobes wrong");
  wr_oe_high_a: assert property (!pins.writeEnN |-> pins.outEnN)
    else $error("output enable low in write");
  rd_no_drive_a: assert property (!pins.outEnN |-> dataLinesOeN)
    else $error("host drives data during read");
  wr_addr_hold_a: assert property (!pins.writeEnN |-> $stable(pins.addressLines))
    else $error("address moved in write");
  wr_data_hold_a: assert property (!pins.writeEnN |=> !dataLinesOeN && $stable(dataLinesOut))
    else $error("data moved before write end");
  idle_deselect_a: assert property (reqReady |-> pins.chipEnN && dataLinesOeN)
    else $error("chip selected while idle");
  id_level_rd_a: assert property (pins.idLevel |-> pins.writeEnN)
    else $error("id level during write");
  rd_answer_a: assert property (reqValid && reqReady && req.op == pfbcp_pkg::OP_READ
    |-> ##[11:15] rspValid) else $error("read answer late");
  prog_len_a: assert property (reqValid && reqReady && req.op == pfbcp_pkg::OP_PROGRAM
    |-> ##[36:38] rspValid) else $error("program length wrong");
endmodule
bind pfbcp_host pfbcp_host_assertions i_chk (.clk(clk), .reset(reset), .reqValid(reqValid),
  .req(req), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .pins(pins),
  .dataLinesOut(dataLinesOut), .dataLinesOeN(dataLinesOeN), .dataLinesIn(dataLinesIn));

// ---- pfbcp_host_bench.sv ----
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module pfbcp_host_bench;
  typedef struct { logic [2:0] op; logic [18:0] a; logic [7:0] d; logic [7:0] e; } pfbcp_row_t;
  logic                   clk = 0;
  logic                   reset = 1;
  logic                   reqValid = 0;
  pfbcp_pkg::pfbcp_req_t  req = '0;
  pfbcp_pkg::pfbcp_pins_t pins;
  logic                   rspValid;
  logic                   reqReady;
  logic                   dataLinesOeN;
  logic [7:0]             rspData;
  logic [7:0]             dataLinesOut;
  wire logic [7:0]        dq;
  wire logic [7:0]        dataLinesIn = dataLinesOeN ? dq : dataLinesOut;
  int                     n_mismatch = 0;
  int                     samples_checked = 0;
  int                     cyc = 0;
  pfbcp_row_t rows [20] = '{
    '{0, 19'h00003, 0, 8'hff}, '{3, 0, 0, 0},
    '{0, 19'h00000, 0, 8'h3c}, '{0, 19'h7ff01, 0, 8'hc3},
    '{0, 19'h70002, 0, 8'h01}, '{0, 19'h60002, 0, 8'h00},
    '{1, 19'h12345, 8'hf0, 0}, '{0, 19'h00000, 0, 8'hff},
    '{5, 19'h00000, 0, 8'h3c}, '{5, 19'h00001, 0, 8'hc3},
    '{4, 19'h00003, 8'h5a, 0}, '{0, 19'h00003, 0, 8'h4c},
    '{0, 19'h00003, 0, 8'h5a}, '{4, 19'h70003, 8'h00, 0},
    '{0, 19'h70003, 0, 8'hff}, '{4, 19'h00003, 8'hff, 0},
    '{1, 19'h00000, 0, 0},     '{0, 19'h00003, 0, 8'h6c},
    '{2, 0, 0, 0},             '{0, 19'h00003, 0, 8'h5a}
  };
  pfbcp_flash_model i_flash (.ceN(pins.chipEnN), .oeN(pins.outEnN), .weN(pins.writeEnN),
    .idLvl(pins.idLevel), .a(pins.addressLines), .din(dataLinesIn), .dq(dq));
  pfbcp_host i_dut (.clk(clk), .reset(reset), .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .pins(pins), .dataLinesOut(dataLinesOut),
    .dataLinesOeN(dataLinesOeN), .dataLinesIn(dataLinesIn));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [2:0] op, input logic [18:0] a, input logic [7:0] d);
    // resets answer before their abort wait ends, so wait for idle first
    do @(posedge clk); while (reqReady !== 1'b1);
    reqValid <= 1;
    req <= '{pfbcp_pkg::pfbcp_op_t'(op), a, d};
    @(posedge clk);
    reqValid <= 0;
    do @(posedge clk); while (rspValid !== 1'b1);
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  // whole run needs about 3400 cycles, mostly three reset abort waits
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch++;
      stop_test;
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 0;
    chk({4'h0, pins.chipEnN, pins.writeEnN, dataLinesOeN, rspValid}, 8'h0e);
    foreach (rows[i])
    begin
      run(rows[i].op, rows[i].a, rows[i].d);
      chk(rspData, rows[i].e);
    end
    // reset lands inside the first unlock write
    @(posedge clk);
    reqValid <= 1;
    req <= '{pfbcp_pkg::OP_IDENT, 19'h0, 8'h0};
    @(posedge clk);
    reqValid <= 0;
    repeat (6) @(posedge clk);
    reset <= 1;
    repeat (2) @(posedge clk);
    chk({4'h0, pins.chipEnN, pins.writeEnN, dataLinesOeN, rspValid}, 8'h0e);
    reset <= 0;
    repeat (2) @(posedge clk);
    chk({7'h0, reqReady}, 8'h01);
    run(3'h0, 19'h00003, 8'h00);
    chk(rspData, 8'h5a);
    stop_test;
  end
endmodule
